// ==== logic/ifh_frame_handler.sv ====
// frame assembly and parsing for the 250 kbps o-qpsk 802.15.4 mode
// assumes synchronous octet strobes from the modem and a byte memory
// that answers a read in the following cycle
//
// The address-and-strobe port and the placing of the registers were decided locally.

// Notes on behaviour
// - mode bit enables 250k o-qpsk framing
// - timing based on 16 us symbols
// - payload at most 127 octets, 125 with crc
// - four zero preamble octets lead each frame
// - delimiter 0xa7 by default, programmable
// - preamble and delimiter never touch memory
// - length from low seven bits, all eight reported
// - length octet first at buffer pointer
// - zero length received frames dropped, no begin event
// - n data octets, last two are crc
// - crc-16 appended on transmit, checked on receive
// - frame control captured raw, only its addressing modes and bit 6 decoded
// - sequence number captured per frame
// - addressing field length derived, zero to 20
// - crc initial value zero, programmable
// - received crc octets not written to memory
// - tx crc computed from first payload octet
module ifh_frame_handler #(
   parameter int OCT_CYC = ifh_pkg::OCT_CYC // cycles per octet
)(
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   input  wire logic [4:0]       reg_addr,
   input  wire logic [31:0]      reg_wdata,
   input  wire logic             reg_wr,
   input  wire logic             reg_rd,
   output logic [31:0]           reg_rdata,
   input  wire ifh_pkg::ifh_oct_t air_rx,
   output ifh_pkg::ifh_oct_t     air_tx,
   output ifh_pkg::ifh_mem_t     mem_req,
   input  wire logic [7:0]       mem_rdata,
   output logic                  frame_begin_event,
   output logic                  frame_end_event,
   output logic                  crc_result_flag,
   output logic [6:0]            rf_freq_offset
);

   // ------------------------------------------------
   // declarations
   // ------------------------------------------------
   localparam int DW = $clog2(OCT_CYC);
   ifh_pkg::ifh_state_t st_q;           // main sequencer
   logic [DW-1:0]       div_q;          // octet divider
   logic [1:0]          ctrl_q;         // mode, crc enable
   logic [7:0]          sfd_q;          // delimiter
   logic [15:0]         ptr_q;          // frame buffer pointer
   logic [6:0]          freq_q;         // frequency setting
   logic [15:0]         cini_q;         // crc initial value
   logic [15:0]         poly_q;         // crc polynomial setting
   logic [1:0]          evt_q;          // sticky begin and end
   logic [7:0]          phr_q;          // last length octet, 8 bits
   logic [7:0]          buf_q;          // prefetched tx octet
   logic                rdp_q;          // read answer due
   logic [6:0]          cnt_q;          // octets left
   logic [2:0]          zc_q;           // preamble zeros seen
   logic [15:0]         crc_q;          // running crc
   logic [15:0]         addr_q;         // next memory address
   logic [7:0]          pos_q;          // rx payload position
   logic [15:0]         fcf_q;          // frame control field
   logic [7:0]          seq_q;          // sequence number
   logic                crc_ok_q;       // crc result
   logic                beg_q;          // begin event pulse
   logic                end_q;          // end event pulse
   ifh_pkg::ifh_oct_t   tx_q;           // air output
   ifh_pkg::ifh_mem_t   mem_q;          // memory request
   logic [31:0]         rd_q;           // read data

   // ------------------------------------------------
   // crc byte update, lsb first
   // ------------------------------------------------
   function automatic logic [15:0] crc8(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] r;
      r = c;
      for (int i = 0; i < 8; i++) begin
         // shift one data bit through the reflected register
         r = (r[0] ^ d[i]) ? ((r >> 1) ^ ifh_pkg::CRC_REV) : (r >> 1);
      end
      return r;
   endfunction : crc8

   // ------------------------------------------------
   // decode and selection
   // ------------------------------------------------
   wire mode_en = ctrl_q[ifh_pkg::B_MODE];
   wire crc_en  = ctrl_q[ifh_pkg::B_CRC];
   wire tick    = (div_q == DW'(OCT_CYC - 1));
   wire wr_ctrl = reg_wr && (reg_addr == ifh_pkg::A_CTRL);
   wire go      = wr_ctrl && reg_wdata[ifh_pkg::B_GO] && reg_wdata[ifh_pkg::B_MODE]
                  && (st_q == ifh_pkg::ST_IDLE);
   wire rx_ok   = air_rx.valid && mode_en;
   wire [6:0] rlen = air_rx.data[6:0];
   wire [6:0] tlen = buf_q[6:0];
   // payload octets fetched from memory; crc octets are made here
   wire [6:0] tdat = !crc_en ? tlen : (tlen < 7'h2) ? 7'h0 : tlen - 7'h2;
   wire [15:0] crc_nxt = crc8(crc_q, air_rx.data);
   wire [15:0] crc_tx  = crc8(crc_q, buf_q);
   // crc octets of a received frame stay out of memory
   wire rx_keep = !crc_en || (cnt_q > 7'h2);
   wire sfd_hit = rx_ok && (zc_q == ifh_pkg::PRE_LEN) && (air_rx.data == sfd_q);
   // addressing length from frame control modes
   wire [1:0] dmode = fcf_q[11:10];
   wire [1:0] smode = fcf_q[15:14];
   wire [4:0] dlen = dmode[1] ? (dmode[0] ? 5'd10 : 5'd4) : 5'd0;
   wire [4:0] slen = smode[1] ? (smode[0] ? 5'd8 : 5'd2) : 5'd0;
   wire [4:0] span = (smode[1] && !fcf_q[6]) ? 5'd2 : 5'd0;
   wire [4:0] alen = dlen + slen + span;
   wire [1:0] evt_set = {end_q, beg_q};
   wire [1:0] evt_clr = (reg_wr && reg_addr == ifh_pkg::A_STAT)
                        ? reg_wdata[ifh_pkg::B_END:ifh_pkg::B_BEG] : 2'b00;
   wire is_tx = st_q inside {ifh_pkg::ST_PRE, ifh_pkg::ST_SFD, ifh_pkg::ST_PHR,
                             ifh_pkg::ST_TDAT, ifh_pkg::ST_TCRC};
   wire is_rx = st_q inside {ifh_pkg::ST_RLEN, ifh_pkg::ST_RDAT};
   wire [31:0] stat_w = {14'h0, evt_q, phr_q, 5'h0, is_rx, is_tx, crc_ok_q};
   wire [31:0] info_w = {3'h0, alen, seq_q, fcf_q};

   // read mux, unmapped offsets answer zero
   wire [31:0] rmux =
      (reg_addr == ifh_pkg::A_CTRL) ? {30'h0, ctrl_q[1:0]} :
      (reg_addr == ifh_pkg::A_SFD)  ? {24'h0, sfd_q} :
      (reg_addr == ifh_pkg::A_PTR)  ? {16'h0, ptr_q} :
      (reg_addr == ifh_pkg::A_STAT) ? stat_w :
      (reg_addr == ifh_pkg::A_FREQ) ? {25'h0, freq_q} :
      (reg_addr == ifh_pkg::A_CINI) ? {16'h0, cini_q} :
      (reg_addr == ifh_pkg::A_POLY) ? {16'h0, poly_q} :
      (reg_addr == ifh_pkg::A_INFO) ? info_w : 32'h0;

   assign reg_rdata         = rd_q;
   assign air_tx            = tx_q;
   assign mem_req           = mem_q;
   assign frame_begin_event = beg_q;
   assign frame_end_event   = end_q;
   assign crc_result_flag   = crc_ok_q;
   assign rf_freq_offset    = freq_q;

   // ------------------------------------------------
   // register file
   // ------------------------------------------------
   // settings and read data; sticky set beats a same-cycle clear
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_q <= 2'h0;
         sfd_q  <= ifh_pkg::SFD_STD;
         ptr_q  <= 16'h0;
         freq_q <= ifh_pkg::FREQ_RST;
         cini_q <= 16'h0;
         poly_q <= ifh_pkg::POLY_RST;
         evt_q  <= 2'b00;
         rd_q   <= 32'h0;
      end else begin
         evt_q <= (evt_q & ~evt_clr) | evt_set;
         rd_q  <= reg_rd ? rmux : 32'h0;
         if (wr_ctrl) ctrl_q <= reg_wdata[1:0];
         if (reg_wr && reg_addr == ifh_pkg::A_SFD) sfd_q <= reg_wdata[7:0];
         if (reg_wr && reg_addr == ifh_pkg::A_PTR) ptr_q <= reg_wdata[15:0];
         if (reg_wr && reg_addr == ifh_pkg::A_FREQ) freq_q <= reg_wdata[6:0];
         if (reg_wr && reg_addr == ifh_pkg::A_CINI) cini_q <= reg_wdata[15:0];
         if (reg_wr && reg_addr == ifh_pkg::A_POLY) poly_q <= reg_wdata[15:0];
      end
   end

   // ------------------------------------------------
   // octet divider
   // ------------------------------------------------
   // restarts with each transmit so the first octet is a full period out
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) div_q <= '0;
      else if (go || tick) div_q <= '0;
      else div_q <= div_q + 1'b1;
   end

   // ------------------------------------------------
   // memory read answer
   // ------------------------------------------------
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rdp_q <= 1'b0;
         buf_q <= 8'h0;
      end else begin
         rdp_q <= mem_q.re;
         if (rdp_q) buf_q <= mem_rdata;
      end
   end

   // ------------------------------------------------
   // sequencer
   // ------------------------------------------------
   // half duplex: air input is ignored while sending
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= ifh_pkg::ST_IDLE;
         cnt_q <= 7'h0;
         zc_q <= 3'h0;
         crc_q <= 16'h0;
         addr_q <= 16'h0;
         pos_q <= 8'h0;
         fcf_q <= 16'h0;
         seq_q <= 8'h0;
         phr_q <= 8'h0;
         crc_ok_q <= 1'b0;
         beg_q <= 1'b0;
         end_q <= 1'b0;
         tx_q <= '0;
         mem_q <= '0;
      end else begin
         beg_q <= 1'b0;
         end_q <= 1'b0;
         tx_q.valid <= 1'b0;
         mem_q.we <= 1'b0;
         mem_q.re <= 1'b0;
         case (st_q)
            ifh_pkg::ST_IDLE: begin
               // fetch the length octet, then start the preamble
               if (go) begin
                  mem_q.re <= 1'b1;
                  mem_q.addr <= ptr_q;
                  addr_q <= ptr_q + 16'h1;
                  cnt_q <= {4'h0, ifh_pkg::PRE_LEN};
                  st_q <= ifh_pkg::ST_PRE;
               end else if (sfd_hit) begin
                  zc_q <= 3'h0;
                  st_q <= ifh_pkg::ST_RLEN;
               end else if (rx_ok) begin
                  // count zero octets, saturating at the preamble length
                  if (air_rx.data != 8'h0) zc_q <= 3'h0;
                  else if (zc_q != ifh_pkg::PRE_LEN) zc_q <= zc_q + 3'h1;
               end
            end
            ifh_pkg::ST_PRE: if (tick) begin
               tx_q <= '{valid: 1'b1, data: 8'h0};
               cnt_q <= cnt_q - 7'h1;
               if (cnt_q == 7'h1) st_q <= ifh_pkg::ST_SFD;
            end
            ifh_pkg::ST_SFD: if (tick) begin
               tx_q <= '{valid: 1'b1, data: sfd_q};
               st_q <= ifh_pkg::ST_PHR;
            end
            ifh_pkg::ST_PHR: if (tick) begin
               // all eight bits of the stored length go out
               tx_q <= '{valid: 1'b1, data: buf_q};
               crc_q <= cini_q;
               cnt_q <= tdat;
               if (tdat != 7'h0) begin
                  mem_q.re <= 1'b1;
                  mem_q.addr <= addr_q;
                  addr_q <= addr_q + 16'h1;
                  st_q <= ifh_pkg::ST_TDAT;
               end else if (crc_en) begin
                  cnt_q <= 7'h2;
                  st_q <= ifh_pkg::ST_TCRC;
               end else begin
                  end_q <= 1'b1;
                  st_q <= ifh_pkg::ST_IDLE;
               end
            end
            ifh_pkg::ST_TDAT: if (tick) begin
               tx_q <= '{valid: 1'b1, data: buf_q};
               crc_q <= crc_tx;
               cnt_q <= cnt_q - 7'h1;
               if (cnt_q != 7'h1) begin
                  mem_q.re <= 1'b1;
                  mem_q.addr <= addr_q;
                  addr_q <= addr_q + 16'h1;
               end else if (crc_en) begin
                  cnt_q <= 7'h2;
                  st_q <= ifh_pkg::ST_TCRC;
               end else begin
                  end_q <= 1'b1;
                  st_q <= ifh_pkg::ST_IDLE;
               end
            end
            ifh_pkg::ST_TCRC: if (tick) begin
               // low octet of the check first, then the high octet
               tx_q <= '{valid: 1'b1, data: crc_q[7:0]};
               crc_q <= {8'h0, crc_q[15:8]};
               cnt_q <= cnt_q - 7'h1;
               if (cnt_q == 7'h1) begin
                  end_q <= 1'b1;
                  st_q <= ifh_pkg::ST_IDLE;
               end
            end
            ifh_pkg::ST_RLEN: if (rx_ok) begin
               phr_q <= air_rx.data;
               if (rlen == 7'h0) begin
                  st_q <= ifh_pkg::ST_IDLE;
               end else begin
                  mem_q <= '{we: 1'b1, re: 1'b0, addr: ptr_q, wdata: air_rx.data};
                  addr_q <= ptr_q + 16'h1;
                  beg_q <= 1'b1;
                  cnt_q <= rlen;
                  crc_q <= cini_q;
                  pos_q <= 8'h0;
                  st_q <= ifh_pkg::ST_RDAT;
               end
            end
            ifh_pkg::ST_RDAT: if (rx_ok) begin
               crc_q <= crc_nxt;
               cnt_q <= cnt_q - 7'h1;
               pos_q <= pos_q + 8'h1;
               if (rx_keep) begin
                  mem_q <= '{we: 1'b1, re: 1'b0, addr: addr_q, wdata: air_rx.data};
                  addr_q <= addr_q + 16'h1;
               end
               // frame control and sequence number
               if (pos_q == 8'h0) fcf_q[7:0] <= air_rx.data;
               if (pos_q == 8'h1) fcf_q[15:8] <= air_rx.data;
               if (pos_q == 8'h2) seq_q <= air_rx.data;
               if (cnt_q == 7'h1) begin
                  // residue over data and check is zero for a good frame
                  crc_ok_q <= crc_en && (crc_nxt == 16'h0);
                  end_q <= 1'b1;
                  st_q <= ifh_pkg::ST_IDLE;
               end
            end
            default: st_q <= ifh_pkg::ST_IDLE;
         endcase
         // leaving the mode abandons any frame in progress
         if (!mode_en && st_q != ifh_pkg::ST_IDLE) st_q <= ifh_pkg::ST_IDLE;
      end
   end

   // ------------------------------------------------
   // checks
   // ------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   // preamble octets are zero
   property p_pre_zero;
      (st_q == ifh_pkg::ST_PRE) && tick && mode_en |=> air_tx.valid && (air_tx.data == 8'h0);
   endproperty
   a_pre_zero: assert property (p_pre_zero) else $error("preamble octet not zero");

   // delimiter follows the last preamble octet
   property p_sfd;
      (st_q == ifh_pkg::ST_SFD) && tick && mode_en |=> air_tx.valid && (air_tx.data == $past(sfd_q));
   endproperty
   a_sfd: assert property (p_sfd) else $error("wrong delimiter sent");

   // memory writes only come from a frame being received
   property p_sync_nomem;
      mem_req.we |-> $past(st_q) inside {ifh_pkg::ST_RLEN, ifh_pkg::ST_RDAT};
   endproperty
   a_sync_nomem: assert property (p_sync_nomem) else $error("write outside rx frame");

   // length octet lands first at the pointer
   property p_phr_first;
      (st_q == ifh_pkg::ST_RLEN) && rx_ok && (rlen != 7'h0) |=>
         mem_req.we && (mem_req.addr == ptr_q) && (mem_req.wdata == $past(air_rx.data)) && frame_begin_event;
   endproperty
   a_phr_first: assert property (p_phr_first) else $error("length octet not stored");

   // zero length drops the frame silently
   property p_zero_drop;
      (st_q == ifh_pkg::ST_RLEN) && rx_ok && (rlen == 7'h0) |=>
         !frame_begin_event && !mem_req.we && (st_q == ifh_pkg::ST_IDLE);
   endproperty
   a_zero_drop: assert property (p_zero_drop) else $error("zero length frame kept");

   // received check octets stay out of memory
   property p_crc_nomem;
      (st_q == ifh_pkg::ST_RDAT) && rx_ok && crc_en && (cnt_q <= 7'h2) |=> !mem_req.we;
   endproperty
   a_crc_nomem: assert property (p_crc_nomem) else $error("crc octet written");

   // flag follows the residue of the last octet
   property p_crc_flag;
      (st_q == ifh_pkg::ST_RDAT) && rx_ok && (cnt_q == 7'h1) |=>
         frame_end_event && (crc_result_flag == (crc_en && ($past(crc_nxt) == 16'h0)));
   endproperty
   a_crc_flag: assert property (p_crc_flag) else $error("crc flag mismatch");

   // octets leave at least three cycles apart, two quiet cycles after each
   property p_octet_rate;
      air_tx.valid |=> !air_tx.valid [*2];
   endproperty
   a_octet_rate: assert property (p_octet_rate) else $error("octets too close");

   // length octet is followed by payload, check or idle at once
   property p_no_gap;
      (st_q == ifh_pkg::ST_PHR) && tick && mode_en |=> (st_q != ifh_pkg::ST_PHR) && air_tx.valid;
   endproperty
   a_no_gap: assert property (p_no_gap) else $error("gap after length octet");

   // receive position never passes the largest frame
   property p_len_max;
      (st_q == ifh_pkg::ST_RDAT) |-> (pos_q < {1'b0, ifh_pkg::MAX_LEN});
   endproperty
   a_len_max: assert property (p_len_max) else $error("length above limit");

endmodule : ifh_frame_handler

// ==== include/ifh_pkg.sv ====
// constants and carriers for the 802.15.4 frame handler
// assumes one 200 MHz clock and an external byte-wide frame memory
package ifh_pkg;

   // ------------------------------------------------
   // timing
   // ------------------------------------------------
   localparam int SYM_NS  = 16000;                 // symbol period, ns
   localparam int CLK_MHZ = 200;                   // system clock rate
   localparam int SYM_CYC = SYM_NS * CLK_MHZ / 1000; // cycles per symbol
   localparam int OCT_CYC = 2 * SYM_CYC;           // two symbols per octet

   // ------------------------------------------------
   // frame format
   // ------------------------------------------------
   localparam logic [2:0]  PRE_LEN = 3'h4;      // zero preamble octets
   localparam logic [7:0]  SFD_STD = 8'ha7;     // standard delimiter
   localparam logic [6:0]  MAX_LEN = 7'h7f;     // largest payload
   localparam logic [15:0] CRC_REV = 16'h8408;  // x16+x12+x5+1, lsb first
   localparam logic [15:0] POLY_RST = 16'h1021; // polynomial setting reset
   localparam logic [6:0]  FREQ_RST = 7'h05;    // lowest channel offset

   // ------------------------------------------------
   // register offsets and fields
   // ------------------------------------------------
   localparam logic [4:0] A_CTRL = 5'h00; // mode, crc enable, tx start
   localparam logic [4:0] A_SFD  = 5'h04; // delimiter value
   localparam logic [4:0] A_PTR  = 5'h08; // frame buffer pointer
   localparam logic [4:0] A_STAT = 5'h0c; // status, sticky events
   localparam logic [4:0] A_FREQ = 5'h10; // frequency setting
   localparam logic [4:0] A_CINI = 5'h14; // crc initial value
   localparam logic [4:0] A_POLY = 5'h18; // crc polynomial setting
   localparam logic [4:0] A_INFO = 5'h1c; // decoded frame control
   localparam int B_MODE = 0;  // ctrl: 250k o-qpsk mode enable
   localparam int B_CRC  = 1;  // ctrl: crc enable
   localparam int B_GO   = 2;  // ctrl: write one starts transmit
   localparam int B_BEG  = 16; // stat: sticky frame begin
   localparam int B_END  = 17; // stat: sticky frame end

   // ------------------------------------------------
   // carriers and states
   // ------------------------------------------------
   typedef struct packed {
      logic       valid; // one-cycle octet strobe
      logic [7:0] data;  // octet, lsb sent first
   } ifh_oct_t;

   typedef struct packed {
      logic        we;    // write strobe
      logic        re;    // read strobe, data next cycle
      logic [15:0] addr;  // byte address
      logic [7:0]  wdata; // write data
   } ifh_mem_t;

   typedef enum logic [7:0] {
      ST_IDLE = 8'h01, // hunting for preamble and delimiter
      ST_PRE  = 8'h02, // sending zero preamble
      ST_SFD  = 8'h04, // sending delimiter
      ST_PHR  = 8'h08, // sending length octet
      ST_TDAT = 8'h10, // sending payload
      ST_TCRC = 8'h20, // sending check octets
      ST_RLEN = 8'h40, // awaiting length octet
      ST_RDAT = 8'h80  // receiving payload
   } ifh_state_t;

endpackage : ifh_pkg

// ==== verif/ifh_peer.sv ====
// frame memory model standing on the far side of the dma port
// assumes byte reads are answered in the following cycle only
module ifh_peer (
   input  wire logic              sys_clk,
   input  wire ifh_pkg::ifh_mem_t mem_req,
   output logic [7:0]             mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [0:255]; // frame bytes, low address bits only
   logic       ans_q;       // a read answer is due
   logic [7:0] val_q;       // byte fetched for that answer
   // one-cycle read latency, writes land in arrival order
   always @(posedge sys_clk) begin
      ans_q <= mem_req.re;
      val_q <= mem[mem_req.addr[7:0]];
      if (mem_req.we) begin
         mem[mem_req.addr[7:0]] <= mem_req.wdata;
      end
   end
   // outside the answer cycle show garbage, not stale data
   assign mem_rdata = ans_q ? val_q : ~val_q;
endmodule : ifh_peer

// ==== verif/ifh_frame_handler_tb.sv ====
// self-checking bench: one transmit frame, two receive frames, registers
// assumes the memory model of ifh_peer and a shortened octet period
module ifh_frame_handler_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int OC = 8;                 // shortened octet period
   logic              sys_clk = 1'b0;
   logic              resetn = 1'b0;
   logic [4:0]        reg_addr = 5'h00;
   logic [31:0]       reg_wdata = 32'h0;
   logic [31:0]       reg_rdata;
   logic              reg_wr = 1'b0;
   logic              reg_rd = 1'b0;
   ifh_pkg::ifh_oct_t air_rx = '0;
   ifh_pkg::ifh_oct_t air_tx;
   ifh_pkg::ifh_mem_t mem_req;
   logic [7:0]        mem_rdata;
   logic              frame_begin_event, frame_end_event, crc_result_flag;
   logic [6:0]        rf_freq_offset;
   int                bad_count = 0, samples_checked = 0, seed = 31190, begins = 0, c, k, fc = 0, sq = 0;
   logic [31:0]       txq[$], wq[$], exq[$]; // seen octets, seen writes, expected
   always #2.5 sys_clk = ~sys_clk;
   ifh_frame_handler #(.OCT_CYC(OC)) i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .air_rx(air_rx),
      .air_tx(air_tx), .mem_req(mem_req), .mem_rdata(mem_rdata), .frame_begin_event(frame_begin_event),
      .frame_end_event(frame_end_event), .crc_result_flag(crc_result_flag), .rf_freq_offset(rf_freq_offset));
   ifh_peer i_peer (.sys_clk(sys_clk), .mem_req(mem_req), .mem_rdata(mem_rdata));
   // collect air octets, memory writes and begin pulses
   always @(posedge sys_clk) begin
      if (air_tx.valid === 1'b1) txq.push_back({24'h0, air_tx.data});
      if (mem_req.we === 1'b1) wq.push_back({8'h0, mem_req.addr, mem_req.wdata});
      if (frame_begin_event === 1'b1) begins++;
   end
   task automatic end_of_test;
      if (bad_count == 0 && samples_checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic cmpq(string n, logic [31:0] g[$], logic [31:0] e[$]);
      chk(n, e.size(), g.size());
      for (int i = 0; i < e.size() && i < g.size(); i++) chk(n, e[i], g[i]);
   endtask : cmpq
   task automatic wr(logic [4:0] a, logic [31:0] v);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [4:0] a, logic [31:0] e, string n);
      @(posedge sys_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 chk(n, e, reg_rdata);
   endtask : rd
   // reference check value, lsb first, zero start
   function automatic int crcb(int c, int b);
      for (int i = 0; i < 8; i++) c = (((c ^ (b >> i)) & 1) != 0) ? ((c >> 1) ^ 'h8408) : (c >> 1);
      return c;
   endfunction : crcb
   task automatic send(logic [7:0] b);
      @(posedge sys_clk);
      air_rx <= '{1'b1, b};
      @(posedge sys_clk);
      air_rx <= '{1'b0, ~b};
   endtask : send
   // zero preamble, delimiter, length, n random bytes, then check octets when n is nonzero
   task automatic rx_frame(logic [7:0] sfd, logic [7:0] phr, int n);
      int cc = 0;
      logic [7:0] d;
      repeat (4) send(8'h00);
      send(sfd);
      send(phr);
      if (phr[6:0] != 7'h0) exq.push_back({16'h0080, phr});
      for (int i = 0; i < n; i++) begin
         d = 8'($random(seed));
         cc = crcb(cc, d);
         if (i < 2) fc = fc | (int'(d) << (8 * i));
         if (i == 2) sq = d;
         exq.push_back({8'h0, 16'(16'h0081 + i), d});
         send(d);
      end
      if (n > 0) begin
         send(8'(cc));
         send(8'(cc >> 8));
      end
      repeat (4) @(posedge sys_clk);
   endtask : rx_frame
   initial begin
      #50us;
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (20) @(posedge sys_clk);
      resetn <= 1'b1;
      chk("freq_rst", 32'h5, {25'h0, rf_freq_offset});
      rd(ifh_pkg::A_SFD, 32'ha7, "sfd_rst");
      rd(5'h1f, 32'h0, "unmapped");
      k = $unsigned($random(seed)) % 16;
      wr(ifh_pkg::A_FREQ, 32'(5 + 5 * k));
      #1 chk("freq", 32'(5 + 5 * k), {25'h0, rf_freq_offset});
      wr(ifh_pkg::A_PTR, 32'h40);
      wr(ifh_pkg::A_CINI, 32'h0);
      wr(ifh_pkg::A_POLY, 32'h11021);
      rd(ifh_pkg::A_POLY, 32'h1021, "poly");
      for (int i = 0; i < 8; i++) i_peer.mem[64 + i] = (i == 0) ? 8'h06 : 8'($random(seed));
      exq = '{0, 0, 0, 0, 'ha7, 6};
      c = 0;
      for (int i = 1; i < 5; i++) begin
         exq.push_back(i_peer.mem[64 + i]);
         c = crcb(c, i_peer.mem[64 + i]);
      end
      exq.push_back(c & 'hff);
      exq.push_back(c >> 8);
      wr(ifh_pkg::A_CTRL, 32'h7);
      k = 0;
      while (frame_end_event !== 1'b1 && k < 2000) begin
         @(posedge sys_clk);
         k++;
      end
      chk("tx_done", 32'h1, {31'h0, frame_end_event});
      @(posedge sys_clk);
      cmpq("tx_octets", txq, exq);
      exq = {};
      wr(ifh_pkg::A_PTR, 32'h80);
      wr(ifh_pkg::A_SFD, 32'h5c);
      rx_frame(8'h5c, 8'h85, 3);
      cmpq("rx_writes", wq, exq);
      chk("crc_flag", 32'h1, {31'h0, crc_result_flag});
      rd(ifh_pkg::A_STAT, 32'h00038501, "status");
      // addressing length from the destination and source modes of the frame control
      k = (fc >> 10) & 3;
      c = (k == 3) ? 10 : (k == 2) ? 4 : 0;
      k = (fc >> 14) & 3;
      c = c + ((k == 3) ? 8 : (k == 2) ? 2 : 0);
      if (k >= 2 && ((fc >> 6) & 1) == 0) c = c + 2;
      rd(ifh_pkg::A_INFO, 32'((c << 24) | (sq << 16) | fc), "info");
      wq = {};
      rx_frame(8'h5c, 8'h00, 0);
      chk("zero_writes", 32'h0, wq.size());
      chk("begin_count", 32'h1, begins);
      end_of_test();
   end
endmodule : ifh_frame_handler_tb
